//--- hw/ldks_core.sv
// ldks_core: command decoder, display memory, multiplexer and key scan.
// assumes: host drives strobe, serial clock and data; pull-up on data.
//
// Notes on behaviour
// [RULE_01] first byte after strobe falls is a command, bit b0 first
// [RULE_02] strobe rising mid-byte resets receiver, partial byte dropped
// [RULE_03] serial clock ignored while strobe is high
// [RULE_04] data sampled on each rising serial clock edge except during a key read
// [RULE_05] read data changes on falling edges, open-drain pull-low
// [RULE_06] mode 00..11 selects 4..7 grids, shared pins become grids
// [RULE_07] power-on mode is 7 grids, 10 segments
// [RULE_08] mode command when b2..b7 are zero, mode in low bits
// [RULE_09] mode change blanks display until display on command
// [RULE_10] mode command with current mode does nothing
// [RULE_11] data setting command: b7=0 b6=1 b5=b4=0, low nibble options
// [RULE_12] data setting options are zero at power-on
// [RULE_13] address command loads pointer, 00H..0DH valid
// [RULE_14] pointer 0EH or above drops display bytes
// [RULE_15] pointer is zero at power-on
// [RULE_16] byte-wide memory, two bytes per digit, bit per segment
// [RULE_17] display control sets on/off and pulse width
// [RULE_18] power-on: display off, pulse width one sixteenth
// [RULE_19] key returns latched once per display cycle end
// [RULE_20] five key bytes: odd source b0/b1, even source b3/b4
// [RULE_21] key read shifts bytes out in order, host picks count
// [RULE_22] frame lasts slot time times grids plus one key slot
// [RULE_23] normal write advances pointer after each stored byte
// [RULE_24] host sends at most fourteen display bytes per burst
// [RULE_25] option bits pick write or key read, auto or fixed address
// [RULE_26] control command: eight dimming steps and a display on bit
`timescale 1ns/100ps
`default_nettype none

module ldks_core (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic serial_clock_i,
  input wire logic select_strobe_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o,
  input wire logic key_return_first_i,
  input wire logic key_return_second_i,
  output logic [9:0] segment_key_source_output_o,
  output logic [2:0] shared_segment_grid_output_o,
  output logic [3:0] grid_output_o,
  output logic [1:0] display_mode_o,
  output logic display_on_o
);

  // ----------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------
  logic [7:0] link_byte;
  logic link_first;
  logic link_toggle;
  logic link_oe;
  logic [39:0] key_hold_r;

  ldks_serial_link u_link (
    .serial_clock_i(serial_clock_i),
    .resetn_i(resetn_i),
    .select_strobe_i(select_strobe_i),
    .serial_data_line_i(serial_data_line_i),
    .key_bits_i(key_hold_r),
    .byte_o(link_byte),
    .first_o(link_first),
    .byte_toggle_o(link_toggle),
    .data_oe_o(link_oe)
  );

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [2:0] tgl_sync_r;
  logic [1:0] stb_sync_r;
  logic [1:0] k1_sync_r;
  logic [1:0] k2_sync_r;
  logic [1:0] oe_sync_r;
  logic byte_ev;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_sync_r <= 3'h0;
      stb_sync_r <= 2'h3;
      k1_sync_r <= 2'h0;
      k2_sync_r <= 2'h0;
      oe_sync_r <= 2'h0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], link_toggle};
      stb_sync_r <= {stb_sync_r[0], select_strobe_i};
      k1_sync_r <= {k1_sync_r[0], key_return_first_i};
      k2_sync_r <= {k2_sync_r[0], key_return_second_i};
      oe_sync_r <= {oe_sync_r[0], link_oe};
    end
  end

  assign byte_ev = tgl_sync_r[2] ^ tgl_sync_r[1];

  // data pin: drive low only, enable follows link
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_data_line_o <= 1'b0;
      serial_data_line_oe_o <= 1'b0;
    end else begin
      serial_data_line_o <= 1'b0; // [RULE_05]
      serial_data_line_oe_o <= oe_sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // command decoder
  // ----------------------------------------------------------------
  logic [1:0] mode_r;
  logic [3:0] opt_r;
  logic [3:0] ptr_r;
  logic [2:0] dim_r;
  logic on_r;
  logic ptr_valid;
  logic data_store;
  logic [7:0] mem_r [0:13];

  assign ptr_valid = ptr_r < ldks_pkg::ADDR_LIMIT; // [RULE_13]
  assign data_store = byte_ev && !link_first &&
                      !opt_r[ldks_pkg::DATA_READ_BIT] && ptr_valid;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= ldks_pkg::MODE_RESET; // [RULE_07]
      opt_r <= ldks_pkg::DATA_OPT_RESET; // [RULE_12]
      ptr_r <= ldks_pkg::ADDR_RESET; // [RULE_15]
      dim_r <= ldks_pkg::DIM_RESET; // [RULE_18]
      on_r <= ldks_pkg::ON_RESET; // [RULE_18]
    end else if (byte_ev && link_first) begin
      case (link_byte[7:6])
        ldks_pkg::CMD_MODE: begin
          if (link_byte[5:2] == 4'h0 && // [RULE_08]
              link_byte[1:0] != mode_r) begin // [RULE_10]
            mode_r <= link_byte[1:0];
            on_r <= 1'b0; // [RULE_09]
          end
        end
        ldks_pkg::CMD_DATA: begin
          if (link_byte[5:4] == 2'h0) begin
            opt_r <= link_byte[3:0]; // [RULE_11] [RULE_25]
          end
        end
        ldks_pkg::CMD_CTRL: begin
          on_r <= link_byte[ldks_pkg::CTRL_ON_BIT]; // [RULE_17] [RULE_26]
          dim_r <= link_byte[2:0];
        end
        ldks_pkg::CMD_ADDR: begin
          ptr_r <= link_byte[3:0]; // [RULE_13]
        end
        default: begin
          ptr_r <= ptr_r;
        end
      endcase
    end else if (data_store && !opt_r[ldks_pkg::DATA_FIXED_BIT]) begin
      ptr_r <= ptr_r + 4'h1; // [RULE_23]
    end
  end

  // display memory, contents undefined until written
  always_ff @(posedge clk_i) begin
    if (data_store) begin
      mem_r[ptr_r] <= link_byte; // [RULE_14] [RULE_16]
    end
  end

  // ----------------------------------------------------------------
  // slot and frame timing
  // ----------------------------------------------------------------
  logic [8:0] phase_r;
  logic [2:0] slot_r;
  logic [2:0] grids;
  logic key_slot;
  logic slot_end;
  logic [3:0] sub;
  logic sub_end;

  assign grids = ldks_pkg::MIN_GRIDS + {1'b0, mode_r}; // [RULE_06]
  assign key_slot = slot_r >= grids;
  assign slot_end = phase_r == ldks_pkg::PHASE_LAST;
  assign sub = phase_r[8:5];
  assign sub_end = phase_r[4:0] == ldks_pkg::SUB_LAST;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= 9'h000;
      slot_r <= 3'h0;
    end else if (slot_end) begin
      phase_r <= 9'h000;
      if (key_slot) begin
        slot_r <= 3'h0; // [RULE_22]
      end else begin
        slot_r <= slot_r + 3'h1;
      end
    end else begin
      phase_r <= phase_r + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // key scan
  // ----------------------------------------------------------------
  logic [9:0] scan_k1_r;
  logic [9:0] scan_k2_r;
  logic [9:0] key_k1_r;
  logic [9:0] key_k2_r;
  logic [39:0] key_bits;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scan_k1_r <= 10'h000;
      scan_k2_r <= 10'h000;
    end else if (key_slot && sub_end && sub < 4'hA) begin
      scan_k1_r[sub] <= k1_sync_r[1];
      scan_k2_r[sub] <= k2_sync_r[1];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_k1_r <= 10'h000;
      key_k2_r <= 10'h000;
    end else if (key_slot && slot_end) begin
      key_k1_r <= scan_k1_r; // [RULE_19]
      key_k2_r <= scan_k2_r;
    end
  end

  for (genvar b = 0; b < ldks_pkg::KEY_BYTES; b++) begin : g_keybyte
    assign key_bits[8*b+0] = key_k1_r[2*b]; // [RULE_20]
    assign key_bits[8*b+1] = key_k2_r[2*b];
    assign key_bits[8*b+2] = 1'b0;
    assign key_bits[8*b+3] = key_k1_r[2*b+1];
    assign key_bits[8*b+4] = key_k2_r[2*b+1];
    assign key_bits[8*b+7:8*b+5] = 3'h0;
  end

  // frozen while strobe is low so the link reads a steady copy
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_hold_r <= 40'h00_0000_0000;
    end else if (stb_sync_r[1]) begin
      key_hold_r <= key_bits; // [RULE_21]
    end
  end

  // ----------------------------------------------------------------
  // segment and grid drive
  // ----------------------------------------------------------------
  logic [15:0] digit;
  logic [3:0] idx_lo;
  logic [3:0] idx_hi;
  logic [3:0] width16;
  logic pulse_on;
  logic [9:0] seg_nxt;
  logic [2:0] shared_nxt;
  logic [3:0] grid_nxt;

  assign idx_lo = {slot_r, 1'b0};
  assign idx_hi = {slot_r, 1'b1};
  assign digit = key_slot ? 16'h0000
                          : {mem_r[idx_hi], mem_r[idx_lo]}; // [RULE_16]
  assign width16 = {dim_r, 1'b1}; // [RULE_26]
  assign pulse_on = on_r && !key_slot && sub < width16; // [RULE_17]

  for (genvar s = 0; s < ldks_pkg::SEG_PINS; s++) begin : g_seg
    assign seg_nxt[s] = key_slot ? (sub == 4'(s))
                                 : (pulse_on && digit[s]);
  end

  for (genvar j = 0; j < ldks_pkg::SHARED_PINS; j++) begin : g_shared
    assign shared_nxt[j] = (mode_r >= 2'(3 - j)) // [RULE_06]
      ? (on_r && !key_slot && slot_r == 3'(6 - j))
      : (pulse_on && digit[10 + j]);
  end

  for (genvar g = 0; g < ldks_pkg::GRID_PINS; g++) begin : g_grid
    assign grid_nxt[g] = on_r && !key_slot && slot_r == 3'(g);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      segment_key_source_output_o <= 10'h000;
      shared_segment_grid_output_o <= 3'h0;
      grid_output_o <= 4'h0;
    end else begin
      segment_key_source_output_o <= seg_nxt;
      shared_segment_grid_output_o <= shared_nxt;
      grid_output_o <= grid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      display_mode_o <= ldks_pkg::MODE_RESET;
      display_on_o <= ldks_pkg::ON_RESET;
    end else begin
      display_mode_o <= mode_r;
      display_on_o <= on_r;
    end
  end

endmodule

`default_nettype wire

//--- shared/ldks_pkg.sv
// ldks_pkg: constants shared by the panel driver core and its serial link.
// assumes: core clock at 20 MHz, link clock supplied by the host.
`default_nettype none

package ldks_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLOT_TIME_NS = 25600;
  localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int PHASE_W = 9;
  localparam logic [8:0] PHASE_LAST = 9'(SLOT_CYCLES - 1);
  localparam logic [4:0] SUB_LAST = 5'h1F;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_MODE = 2'h0;
  localparam logic [1:0] CMD_DATA = 2'h1;
  localparam logic [1:0] CMD_CTRL = 2'h2;
  localparam logic [1:0] CMD_ADDR = 2'h3;
  localparam int DATA_READ_BIT = 1;
  localparam int DATA_FIXED_BIT = 2;
  localparam int CTRL_ON_BIT = 3;

  // ----------------------------------------------------------------
  // power-on values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_RESET = 2'h3;
  localparam logic [3:0] DATA_OPT_RESET = 4'h0;
  localparam logic [3:0] ADDR_RESET = 4'h0;
  localparam logic [2:0] DIM_RESET = 3'h0;
  localparam logic ON_RESET = 1'b0;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_LIMIT = 4'hE;
  localparam int MEM_DEPTH = 14;
  localparam logic [2:0] MIN_GRIDS = 3'h4;
  localparam int SEG_PINS = 10;
  localparam int SHARED_PINS = 3;
  localparam int GRID_PINS = 4;
  localparam int KEY_BYTES = 5;
  localparam int KEY_BITS = 40;
  localparam logic [5:0] KEY_BIT_LAST = 6'h27;

endpackage

`default_nettype wire

//--- hw/ldks_serial_link.sv
// ldks_serial_link: byte receiver and key data sender on the host clock.
// assumes: key_bits_i is held stable by the core while strobe is low.
`timescale 1ns/100ps
`default_nettype none

module ldks_serial_link (
  input wire logic serial_clock_i,
  input wire logic resetn_i,
  input wire logic select_strobe_i,
  input wire logic serial_data_line_i,
  input wire logic [39:0] key_bits_i,
  output logic [7:0] byte_o,
  output logic first_o,
  output logic byte_toggle_o,
  output logic data_oe_o
);

  // ----------------------------------------------------------------
  // receiver held in reset while strobe is high
  // ----------------------------------------------------------------
  logic link_rstn;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic first_r;
  logic read_busy_r;
  logic [7:0] byte_nxt;
  logic [5:0] rd_idx_r;

  assign link_rstn = resetn_i & ~select_strobe_i; // [RULE_02] [RULE_03]
  assign byte_nxt = {serial_data_line_i, shift_r}; // [RULE_01]

  // sample on rising edge, lsb first
  always_ff @(posedge serial_clock_i or negedge link_rstn) begin
    if (!link_rstn) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      first_r <= 1'b1;
      read_busy_r <= 1'b0;
    end else if (!read_busy_r) begin
      shift_r <= byte_nxt[7:1]; // [RULE_04]
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        first_r <= 1'b0;
        if (first_r && byte_nxt[7:6] == ldks_pkg::CMD_DATA &&
            byte_nxt[5:4] == 2'h0 && byte_nxt[ldks_pkg::DATA_READ_BIT]) begin
          read_busy_r <= 1'b1; // [RULE_21]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // completed byte, kept across strobe for the core to fetch
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_o <= 8'h00;
      first_o <= 1'b0;
      byte_toggle_o <= 1'b0;
    end else if (link_rstn && !read_busy_r && bit_cnt_r == 3'h7) begin
      byte_o <= byte_nxt;
      first_o <= first_r; // [RULE_01]
      byte_toggle_o <= ~byte_toggle_o;
    end
  end

  // ----------------------------------------------------------------
  // key data out on falling edge, pull low only
  // ----------------------------------------------------------------
  always_ff @(negedge serial_clock_i or negedge link_rstn) begin
    if (!link_rstn) begin
      rd_idx_r <= 6'h00;
      data_oe_o <= 1'b0;
    end else if (read_busy_r) begin
      data_oe_o <= ~key_bits_i[rd_idx_r]; // [RULE_05]
      if (rd_idx_r == ldks_pkg::KEY_BIT_LAST) begin
        rd_idx_r <= 6'h00;
      end else begin
        rd_idx_r <= rd_idx_r + 6'h01; // [RULE_21]
      end
    end
  end

endmodule

`default_nettype wire

//--- test/ldks_core_sva.sv
// ldks_core_sva: port checks on the panel driver core.
// assumes: bound to ldks_core, clk_i at 20 MHz.
`timescale 1ns/100ps
`default_nettype none

module ldks_core_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic select_strobe_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe_o,
  input wire logic [9:0] segment_key_source_output_o,
  input wire logic [2:0] shared_segment_grid_output_o,
  input wire logic [3:0] grid_output_o,
  input wire logic [1:0] display_mode_o,
  input wire logic display_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic g0_d_r;
  logic on_d_r;
  logic seen_r;
  logic [12:0] start_r;
  // ----------------------------------------------------------------
  // cycles between starts of digit one
  // ----------------------------------------------------------------
  // only a start seen with display already on opens a measured frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      g0_d_r <= 1'b0;
      on_d_r <= 1'b0;
      seen_r <= 1'b0;
      start_r <= 13'h0000;
    end else begin
      g0_d_r <= grid_output_o[0];
      on_d_r <= display_on_o;
      start_r <= (grid_output_o[0] && !g0_d_r) ? 13'h0001 : start_r + 13'h0001;
      if (!display_on_o) begin
        seen_r <= 1'b0;
      end else if (grid_output_o[0] && !g0_d_r) begin
        seen_r <= on_d_r;
      end
    end
  end
  property p_reset_vals;
    $rose(resetn_i) |-> display_mode_o == 2'h3 && !display_on_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("power-on mode or display state wrong");
  property p_od_low;
    serial_data_line_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("data pin driven high");
  property p_oe_idle;
    select_strobe_i [*4] |-> !serial_data_line_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pin pulled low while deselected");
  property p_cfg_quiet;
    select_strobe_i [*8] |-> $stable(display_mode_o) && $stable(display_on_o);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("configuration changed while deselected");
  property p_blank_on_mode;
    $changed(display_mode_o) |-> ##[0:2] !display_on_o;
  endproperty
  a_blank_on_mode: assert property (p_blank_on_mode)
    else $error("display left on after mode change");
  property p_dark_off;
    !display_on_o [*3] |-> grid_output_o == 4'h0;
  endproperty
  a_dark_off: assert property (p_dark_off)
    else $error("grid driven while display off");
  property p_one_grid;
    $onehot0({display_mode_o == 2'h3 ? shared_segment_grid_output_o : 3'h0,
              grid_output_o});
  endproperty
  a_one_grid: assert property (p_one_grid)
    else $error("more than one grid selected");
  property p_pulse_width;
    $rose(grid_output_o[0]) |->
      ##[1:480] segment_key_source_output_o == 10'h000;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("digit pulse longer than widest step");
  property p_frame_len;
    $rose(grid_output_o[0]) && seen_r |->
      start_r == {4'(display_mode_o) + 4'h5, 9'h000};
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length differs from grids plus one slots");
endmodule

bind ldks_core ldks_core_sva i_sva (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .select_strobe_i(select_strobe_i),
  .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe_o(serial_data_line_oe_o),
  .segment_key_source_output_o(segment_key_source_output_o),
  .shared_segment_grid_output_o(shared_segment_grid_output_o),
  .grid_output_o(grid_output_o),
  .display_mode_o(display_mode_o),
  .display_on_o(display_on_o)
);
`default_nettype wire

//--- test/ldks_host_model.sv
// ldks_host_model: host side of the serial link, strobe, clock and data.
// assumes: bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module ldks_host_model #(
  parameter real HALF_NS = 62.5,
  parameter real READ_LOW_NS = 300.0
) (
  input wire logic line_i,
  output logic sclk_o,
  output logic strobe_o,
  output logic drive_o,
  output logic drive_oe_o
);
  initial begin
    sclk_o = 1'b1;
    strobe_o = 1'b1;
    drive_o = 1'b1;
    drive_oe_o = 1'b0;
  end
  task automatic begin_frame;
    strobe_o = 1'b0;
    #1000;
  endtask
  // n bits, b0 first, data set while clock low
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      drive_oe_o = 1'b1;
      drive_o = b[i];
      #(HALF_NS);
      sclk_o = 1'b1;
      #(HALF_NS);
    end
  endtask
  // release data, strobe high for at least 1 us
  task automatic end_frame;
    #(HALF_NS);
    drive_oe_o = 1'b0;
    drive_o = ~drive_o;
    strobe_o = 1'b1;
    #1000;
  endtask
  // host samples on rising edges, line released
  task automatic read_byte(output logic [7:0] b);
    drive_oe_o = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sclk_o = 1'b0;
      #(READ_LOW_NS);
      sclk_o = 1'b1;
      b[i] = line_i;
      #(HALF_NS);
    end
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// tb: self-checking bench for the panel driver core.
// assumes: host model drives the link, bench models pull-up and keys.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module tb;
  int seed = 54;
  int num_errors = 0;
  int checks = 0;
  int w;
  logic clk_i;
  logic resetn_i;
  logic key_return_first_i;
  logic key_return_second_i;
  logic sclk, strobe, drv, drv_oe, dut_o, dut_oe, line, on;
  logic [9:0] seg, k1_mask, k2_mask;
  logic [2:0] shared;
  logic [3:0] grid;
  logic [1:0] mode;
  logic [7:0] rb, b;
  logic [2:0] dim;
  logic [7:0] mem [14];
  assign line = (dut_oe ? dut_o : 1'b1) & (drv_oe ? drv : 1'b1);

  ldks_host_model i_host (.line_i(line), .sclk_o(sclk), .strobe_o(strobe),
    .drive_o(drv), .drive_oe_o(drv_oe));
  ldks_core i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .serial_clock_i(sclk), .select_strobe_i(strobe),
    .serial_data_line_i(line), .serial_data_line_o(dut_o),
    .serial_data_line_oe_o(dut_oe),
    .key_return_first_i(key_return_first_i),
    .key_return_second_i(key_return_second_i),
    .segment_key_source_output_o(seg),
    .shared_segment_grid_output_o(shared), .grid_output_o(grid),
    .display_mode_o(mode), .display_on_o(on));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    key_return_first_i <= |(seg & k1_mask);
    key_return_second_i <= |(seg & k2_mask);
  end
  function automatic logic [7:0] key_exp(input int i);
    return {3'h0, k2_mask[2*i+1], k1_mask[2*i+1], 1'h0, k2_mask[2*i],
            k1_mask[2*i]};
  endfunction
  task automatic complete_run;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmd_frame(input logic [7:0] c);
    i_host.begin_frame();
    i_host.shift(c, 8);
    i_host.end_frame();
  endtask
  task automatic wait_lvl(input int k, input logic v);
    int n;
    n = 0;
    while (grid[k] !== v && n < 9000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 9000) num_errors++;
  endtask
  // burst of at most fourteen bytes
  task automatic write_mem(input int ad, input int n, input logic fixed);
    cmd_frame(fixed ? 8'h44 : 8'h40);
    i_host.begin_frame();
    i_host.shift(8'hC0 | 8'(ad), 8);
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      i_host.shift(b, 8);
      if (ad < 14) mem[ad] = b;
      if (!fixed) ad++;
    end
    i_host.end_frame();
  endtask
  task automatic check_digits;
    for (int k = 0; k < 4; k++) begin
      wait_lvl(k, 1'b0);
      wait_lvl(k, 1'b1);
      @(posedge clk_i);
      #1;
      `CHK({shared, seg}, {mem[2*k+1][4:0], mem[2*k]})
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    k1_mask = 10'h000;
    k2_mask = 10'h000;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(mode, 2'h3)
    `CHK(on, 1'b0)
    i_host.shift(8'h01, 8);
    i_host.end_frame();
    `CHK(mode, 2'h3)
    cmd_frame(8'h05);
    `CHK(mode, 2'h3)
    i_host.begin_frame();
    i_host.shift(8'hC0, 8);
    i_host.shift(8'hFF, 8);
    i_host.end_frame();
    for (int d = 0; d < 3; d++) begin
      dim = (d == 0) ? 3'h0 : (d == 1) ? 3'h7 : 3'($random(seed));
      cmd_frame(8'h88 | 8'(dim));
      `CHK(on, 1'b1)
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      w = 0;
      while (seg[0] === 1'b1 && w < 600) begin
        @(posedge clk_i);
        #1;
        w++;
      end
      `CHK(w, (2 * int'(dim) + 1) * 32)
    end
    cmd_frame(8'h00);
    `CHK(mode, 2'h0)
    `CHK(on, 1'b0)
    cmd_frame(8'h88);
    cmd_frame(8'h00);
    `CHK(on, 1'b1)
    write_mem(0, 14, 1'b0);
    check_digits();
    write_mem(15, 2, 1'b0);
    write_mem(2, 2, 1'b1);
    i_host.begin_frame();
    i_host.shift(8'hC1, 8);
    i_host.shift(8'($random(seed)), 5);
    i_host.end_frame();
    check_digits();
    k1_mask <= 10'($random(seed));
    k2_mask <= 10'($random(seed));
    repeat (6000) @(posedge clk_i);
    i_host.begin_frame();
    i_host.shift(8'h42, 8);
    #1000;
    for (int i = 0; i < 6; i++) begin
      i_host.read_byte(rb);
      `CHK(rb, key_exp(i % 5))
    end
    i_host.end_frame();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({mode, on}, 3'h6)
    i_host.begin_frame();
    i_host.shift(8'h8F, 8);
    mem[0] = 8'($random(seed));
    i_host.shift(mem[0], 8);
    i_host.end_frame();
    cmd_frame(8'h8F);
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    @(posedge clk_i);
    #1;
    `CHK(seg[7:0], mem[0])
    complete_run();
  end
  initial begin
    #4000000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
